// [shared/rre_pkg.sv]
/*
 Package for the return and rotate execution unit: operation codes,
 datapath widths, reset values and timing counts.
 Assumes a single core clock and an 8-bit data path.
*/
`default_nettype none
package rre_pkg;
   // ==========================================================
   // widths
   localparam int RRE_DATA_W = 8;
   localparam int RRE_PC_W = 13;
   localparam int RRE_OP_W = 3;
   // ==========================================================
   // operation codes
   localparam logic [2:0] RRE_OP_NONE = 3'h0;
   localparam logic [2:0] RRE_OP_RET_IMM = 3'h1;
   localparam logic [2:0] RRE_OP_RET_IRQ = 3'h2;
   localparam logic [2:0] RRE_OP_ROL_MEM = 3'h3;
   localparam logic [2:0] RRE_OP_ROL_ACC = 3'h4;
   localparam logic [2:0] RRE_OP_ROLC_MEM = 3'h5;
   localparam logic [2:0] RRE_OP_ROLC_ACC = 3'h6;
   localparam logic [2:0] RRE_OP_ROR_MEM = 3'h7;
   // ==========================================================
   // field positions and reset values
   localparam int RRE_MSB = 7;
   localparam int RRE_LSB = 0;
   localparam logic [7:0] RRE_ACC_RST = 8'h00;
   localparam logic [12:0] RRE_PC_RST = 13'h0000;
   localparam logic RRE_CARRY_RST = 1'b0;
   localparam logic RRE_MIE_RST = 1'b0;
   // ==========================================================
   // timing: every operation retires one cycle after it is issued
   localparam int RRE_EXEC_CYCLES = 1;
endpackage
`default_nettype wire

// [hdl/rre_rotator.sv]
/*
 Combinational rotate unit: circular or through-carry left and right
 rotate of one byte by one position.
 Assumes the caller registers the result.
*/
`timescale 1ns/10ps
`default_nettype none
module rre_rotator
   import rre_pkg::*;
#(
   parameter int DATA_W = RRE_DATA_W
) (
   // operand
   input wire logic [DATA_W-1:0] data_in,
   input wire logic carry_in,
   // control
   input wire logic through_carry_in,
   input wire logic right_in,
   // result
   output logic [DATA_W-1:0] result_out,
   output logic carry_out
);
   logic fill;

   always_comb begin
      if (right_in) begin
         fill = through_carry_in ? carry_in : data_in[0];
         result_out = {fill, data_in[DATA_W-1:1]};
         carry_out = data_in[0];
      end else begin
         fill = through_carry_in ? carry_in : data_in[DATA_W-1];
         result_out = {data_in[DATA_W-2:0], fill};
         carry_out = data_in[DATA_W-1];
      end
   end
endmodule
`default_nettype wire

// [hdl/rre_exec_unit.sv]
/*
 Execution unit for return and rotate instructions of a small 8-bit core:
 holds the accumulator, carry, master interrupt enable and program counter
 copy, and issues memory write-back and stack pop strobes.
 Assumes the core presents one operation per issue pulse, with the memory
 byte and popped stack word already valid in that cycle, and that the
 interrupt controller consumes irq_take_out.
 Limitation: one operation per cycle; the stack pop strobe is combinational
 from issue_in and op_in, so the stack must take it in the issue cycle.
 Carry and master enable loads from other instructions share this unit;
 a through-carry rotate wins over a carry load in the same cycle.
*/
// What this block does
// (RQ1) Return-with-immediate: pop stack into PC, load immediate into accumulator, no flags.
// (RQ2) Return-from-interrupt: pop stack into PC, set master interrupt enable, no flags.
// (RQ3) Pending interrupt at return-from-interrupt is serviced before the main program resumes.
// (RQ4) Plain left rotate: bit 7 into bit 0, written to memory, no flags.
// (RQ5) Left rotate to accumulator: same rotate into accumulator, memory unchanged, no flags.
// (RQ6) Left rotate through carry: old carry to bit 0, bit 7 to carry, to memory.
// (RQ7) Left rotate through carry to accumulator: accumulator and carry updated, memory unchanged.
// (RQ8) Plain right rotate: bit 0 into bit 7, written to memory, no flags.
`timescale 1ns/10ps
`default_nettype none
module rre_exec_unit
   import rre_pkg::*;
#(
   parameter int DATA_W = RRE_DATA_W,
   parameter int PC_W = RRE_PC_W
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // issue
   input wire logic issue_in,
   input wire logic [2:0] op_in,
   input wire logic [DATA_W-1:0] imm_in,
   input wire logic [DATA_W-1:0] mem_rdata_in,
   input wire logic [PC_W-1:0] stack_top_in,
   input wire logic irq_pending_in,
   // state loads from other instructions
   input wire logic carry_load_in,
   input wire logic carry_value_in,
   input wire logic mie_clear_in,
   // memory write-back
   output logic mem_we_out,
   output logic [DATA_W-1:0] mem_wdata_out,
   // stack and program counter
   output logic stack_pop_out,
   output logic pc_load_out,
   output logic [PC_W-1:0] pc_out,
   // interrupt hand-off
   output logic irq_take_out,
   // architectural state
   output logic [DATA_W-1:0] acc_out,
   output logic carry_out,
   output logic master_irq_enable_out
);
   // ==========================================================
   // decode
   typedef enum logic [1:0] {RRE_DST_NONE, RRE_DST_MEM, RRE_DST_ACC} rre_dst_e;

   function automatic logic rre_is_rot(input logic [2:0] op);
      return op inside {RRE_OP_ROL_MEM, RRE_OP_ROL_ACC, RRE_OP_ROLC_MEM,
                        RRE_OP_ROLC_ACC, RRE_OP_ROR_MEM};
   endfunction

   function automatic logic rre_is_thru(input logic [2:0] op);
      return (op == RRE_OP_ROLC_MEM) || (op == RRE_OP_ROLC_ACC);
   endfunction

   function automatic logic rre_is_ret(input logic [2:0] op);
      return (op == RRE_OP_RET_IMM) || (op == RRE_OP_RET_IRQ);
   endfunction

   function automatic rre_dst_e rre_dst_of(input logic [2:0] op);
      unique case (op)
         RRE_OP_ROL_MEM, RRE_OP_ROLC_MEM, RRE_OP_ROR_MEM: return RRE_DST_MEM;
         RRE_OP_ROL_ACC, RRE_OP_ROLC_ACC: return RRE_DST_ACC;
         default: return RRE_DST_NONE;
      endcase
   endfunction

   // declared ahead of the rotator, which reads carry_reg
   logic [DATA_W-1:0] acc_reg, acc_next;
   logic carry_reg, carry_next;
   logic mie_reg, mie_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic pc_load_reg, pc_load_next;
   logic mem_we_reg, mem_we_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic take_reg, take_next;
   logic rot_thru;
   logic rot_right;
   logic [DATA_W-1:0] rot_result;
   logic rot_carry;
   rre_dst_e dst;

   always_comb begin
      rot_thru = rre_is_thru(op_in);
      rot_right = (op_in == RRE_OP_ROR_MEM);
      dst = rre_dst_of(op_in);
   end

   rre_rotator #(
      .DATA_W(DATA_W)
   ) i_rre_rotator (
      .data_in(mem_rdata_in),
      .carry_in(carry_reg),
      .through_carry_in(rot_thru),
      .right_in(rot_right),
      .result_out(rot_result),
      .carry_out(rot_carry)
   );

   // ==========================================================
   // accumulator, carry and master interrupt enable
   always_comb begin
      acc_next = acc_reg;
      carry_next = carry_reg;
      mie_next = mie_reg;
      if (carry_load_in) begin
         carry_next = carry_value_in;
      end
      // clear comes first so a return from interrupt in the same cycle wins
      if (mie_clear_in) begin
         mie_next = 1'b0;
      end
      if (issue_in) begin
         unique case (op_in)
            RRE_OP_RET_IMM: begin
               acc_next = imm_in; // RQ1
            end
            RRE_OP_RET_IRQ: begin
               mie_next = 1'b1; // RQ2
            end
            default: begin
            end
         endcase
         if (rre_is_rot(op_in) && (dst == RRE_DST_ACC)) begin
            acc_next = rot_result; // RQ5 RQ7
         end
         // only the through-carry forms touch carry, over any carry load
         if (rre_is_rot(op_in) && rot_thru) begin
            carry_next = rot_carry; // RQ6 RQ7
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_reg <= RRE_ACC_RST;
         carry_reg <= RRE_CARRY_RST;
         mie_reg <= RRE_MIE_RST;
      end else begin
         acc_reg <= acc_next;
         carry_reg <= carry_next;
         mie_reg <= mie_next;
      end
   end

   // ==========================================================
   // program counter copy
   always_comb begin
      pc_next = pc_reg;
      pc_load_next = 1'b0;
      if (issue_in && rre_is_ret(op_in)) begin
         pc_next = stack_top_in; // RQ1 RQ2
         pc_load_next = 1'b1; // RQ1 RQ2
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_reg <= RRE_PC_RST;
         pc_load_reg <= 1'b0;
      end else begin
         pc_reg <= pc_next;
         pc_load_reg <= pc_load_next;
      end
   end

   // ==========================================================
   // memory write-back and interrupt hand-off strobes
   always_comb begin
      mem_we_next = 1'b0;
      wdata_next = wdata_reg;
      take_next = 1'b0;
      if (issue_in && rre_is_rot(op_in) && (dst == RRE_DST_MEM)) begin
         mem_we_next = 1'b1; // RQ4 RQ6 RQ8
         wdata_next = rot_result; // RQ4 RQ6 RQ8
      end
      // pending request is handed over in the cycle the return lands
      if (issue_in && (op_in == RRE_OP_RET_IRQ)) begin
         take_next = irq_pending_in; // RQ3
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_we_reg <= 1'b0;
         wdata_reg <= RRE_ACC_RST;
         take_reg <= 1'b0;
      end else begin
         mem_we_reg <= mem_we_next;
         wdata_reg <= wdata_next;
         take_reg <= take_next;
      end
   end

   // ==========================================================
   // outputs
   // pop is issued in the same cycle as the return so the stack sees one pop per return
   assign stack_pop_out = issue_in && rre_is_ret(op_in); // RQ1 RQ2
   assign mem_we_out = mem_we_reg;
   assign mem_wdata_out = wdata_reg;
   assign pc_load_out = pc_load_reg;
   assign pc_out = pc_reg;
   assign irq_take_out = take_reg; // RQ3
   assign acc_out = acc_reg;
   assign carry_out = carry_reg;
   assign master_irq_enable_out = mie_reg;
endmodule
`default_nettype wire

// [bench/rre_exec_unit_assertions.sv]
/*
 Checker for the return and rotate execution unit, bound to its ports.
 Assumes one clock, async active-low reset, answers one cycle after issue.
*/
`timescale 1ns/10ps
`default_nettype none
module rre_exec_unit_assertions
   import rre_pkg::*;
(
   // design inputs
   input wire logic clock_in, rst_n_in, issue_in, irq_pending_in, carry_load_in,
   input wire logic [2:0] op_in,
   input wire logic [7:0] imm_in, mem_rdata_in,
   input wire logic [12:0] stack_top_in,
   // design outputs
   input wire logic mem_we_out, stack_pop_out, pc_load_out, irq_take_out, carry_out,
   input wire logic master_irq_enable_out,
   input wire logic [7:0] mem_wdata_out, acc_out,
   input wire logic [12:0] pc_out
);
   // ==========================================================
   // helpers
   wire [7:0] rotl = {mem_rdata_in[6:0], mem_rdata_in[7]};
   wire [7:0] rotc = {mem_rdata_in[6:0], carry_out};
   wire take_cause = issue_in && op_in == RRE_OP_RET_IRQ && irq_pending_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_op(logic [2:0] op);
      issue_in && op_in == op;
   endsequence
   sequence s_quiet(logic [2:0] op);
      s_op(op) ##0 !carry_load_in;
   endsequence
   // ==========================================================
   // properties
   a_ret_imm_load: assert property (s_quiet(RRE_OP_RET_IMM) |=> pc_load_out &&
      pc_out == $past(stack_top_in) && acc_out == $past(imm_in) && $stable(carry_out))
      else $error("return with immediate wrong");
   a_ret_irq_mie: assert property (s_quiet(RRE_OP_RET_IRQ) |=> pc_load_out &&
      master_irq_enable_out && pc_out == $past(stack_top_in) && $stable(carry_out))
      else $error("return from interrupt wrong");
   a_irq_take_cause: assert property (irq_take_out == $past(take_cause))
      else $error("interrupt take strobe wrong");
   a_pop_strobe: assert property (stack_pop_out ==
      (issue_in && (op_in == RRE_OP_RET_IMM || op_in == RRE_OP_RET_IRQ)))
      else $error("stack pop strobe wrong");
   a_rol_mem_write: assert property (s_quiet(RRE_OP_ROL_MEM) |=> mem_we_out &&
      mem_wdata_out == $past(rotl) && $stable(carry_out) && $stable(acc_out))
      else $error("left rotate to memory wrong");
   a_rol_acc_load: assert property (s_quiet(RRE_OP_ROL_ACC) |=> !mem_we_out &&
      acc_out == $past(rotl) && $stable(carry_out))
      else $error("left rotate to accumulator wrong");
   a_rolc_mem_write: assert property (s_op(RRE_OP_ROLC_MEM) |=> mem_we_out &&
      mem_wdata_out == $past(rotc) && carry_out == $past(mem_rdata_in[7]))
      else $error("carry rotate to memory wrong");
   a_rolc_acc_load: assert property (s_op(RRE_OP_ROLC_ACC) |=> !mem_we_out &&
      acc_out == $past(rotc) && carry_out == $past(mem_rdata_in[7]))
      else $error("carry rotate to accumulator wrong");
   a_ror_mem_write: assert property (s_quiet(RRE_OP_ROR_MEM) |=> mem_we_out &&
      mem_wdata_out == {$past(mem_rdata_in[0]), $past(mem_rdata_in[7:1])} &&
      $stable(carry_out)) else $error("right rotate to memory wrong");
endmodule
bind rre_exec_unit rre_exec_unit_assertions i_rre_exec_unit_assertions (.clock_in, .rst_n_in,
   .issue_in, .irq_pending_in, .carry_load_in, .op_in, .imm_in, .mem_rdata_in, .stack_top_in,
   .mem_we_out, .stack_pop_out, .pc_load_out, .irq_take_out, .carry_out,
   .master_irq_enable_out, .mem_wdata_out, .acc_out, .pc_out);
`default_nettype wire

// [bench/return_and_rotate_exec_unit_tb.sv]
/*
 Self-checking bench for the return and rotate execution unit.
 Assumes inputs are taken at the rising edge and answers show one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec_unit_tb
   import rre_pkg::*;
;
   typedef struct packed {logic [2:0] op; logic [7:0] mem; logic cin;
      logic [7:0] exp; logic exp_c; logic we;} rre_row_s;
   logic clock_in = 0, rst_n_in = 0, issue_in = 0, irq_pending_in = 0;
   logic carry_load_in = 0, carry_value_in = 0, mie_clear_in = 0;
   logic [2:0] op_in = 3'h0;
   logic [7:0] imm_in = 8'h00, mem_rdata_in = 8'h00, mem_wdata_out, acc_out;
   logic [12:0] stack_top_in = 13'h0000, pc_out;
   logic mem_we_out, stack_pop_out, pc_load_out, irq_take_out, carry_out;
   logic master_irq_enable_out;
   int miscompares = 0, checked = 0;
   // rotate cases: exp is the write data for memory ops, the accumulator otherwise
   rre_row_s rows [8] = '{'{3'h3, 8'h81, 1'b1, 8'h03, 1'b1, 1'b1},
      '{3'h4, 8'h80, 1'b0, 8'h01, 1'b0, 1'b0}, '{3'h5, 8'h80, 1'b0, 8'h00, 1'b1, 1'b1},
      '{3'h5, 8'h7F, 1'b1, 8'hFF, 1'b0, 1'b1}, '{3'h6, 8'h80, 1'b1, 8'h01, 1'b1, 1'b0},
      '{3'h6, 8'h01, 1'b0, 8'h02, 1'b0, 1'b0}, '{3'h7, 8'h01, 1'b0, 8'h80, 1'b0, 1'b1},
      '{3'h7, 8'hFE, 1'b1, 8'h7F, 1'b1, 1'b1}};
   rre_exec_unit i_rre_exec_unit (.clock_in, .rst_n_in, .issue_in, .op_in, .imm_in,
      .mem_rdata_in, .stack_top_in, .irq_pending_in, .carry_load_in, .carry_value_in,
      .mie_clear_in, .mem_we_out, .mem_wdata_out, .stack_pop_out, .pc_load_out, .pc_out,
      .irq_take_out, .acc_out, .carry_out, .master_irq_enable_out);
   always #25 clock_in = ~clock_in;
   // ==========================================================
   // tasks
   task automatic step;
      @(posedge clock_in);
      #1;
   endtask
   task automatic issue(input logic [2:0] op);
      issue_in = 1;
      op_in = op;
      step;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // sequence
   initial begin
      repeat (4) step;
      chk({acc_out, carry_out, master_irq_enable_out}, 13'h0000);
      chk(pc_out, 13'h0000);
      rst_n_in = 1;
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         step;
         carry_load_in = 1;
         carry_value_in = rows[i].cin;
         step;
         carry_load_in = 0;
         mem_rdata_in = rows[i].mem;
         issue(rows[i].op);
         issue_in = 0;
         chk(mem_we_out, rows[i].we);
         chk(rows[i].we ? mem_wdata_out : acc_out, rows[i].exp);
         chk(carry_out, rows[i].exp_c);
      end
      $display("rotate table done");
      step;
      imm_in = 8'h5A;
      stack_top_in = 13'h0123;
      issue_in = 1;
      op_in = RRE_OP_RET_IMM;
      #1 chk(stack_pop_out, 1);
      step;
      issue_in = 0;
      chk({pc_load_out, pc_out}, 14'h2123);
      chk({acc_out, carry_out}, 9'h0B5);
      step;
      irq_pending_in = 1;
      stack_top_in = 13'h1456;
      issue(RRE_OP_RET_IRQ);
      chk({pc_load_out, pc_out}, 14'h3456);
      chk({master_irq_enable_out, irq_take_out, carry_out}, 3'h7);
      irq_pending_in = 0;
      mie_clear_in = 1;
      issue(RRE_OP_RET_IRQ);
      chk({pc_load_out, irq_take_out, master_irq_enable_out}, 3'h5);
      issue(RRE_OP_NONE);
      issue_in = 0;
      mie_clear_in = 0;
      chk({mem_we_out, pc_load_out, irq_take_out, master_irq_enable_out}, 4'h0);
      $display("return tests done");
      rst_n_in = 0;
      #1 chk({acc_out, carry_out, master_irq_enable_out, pc_load_out}, 13'h0000);
      chk(pc_out, 13'h0000);
      step;
      rst_n_in = 1;
      mem_rdata_in = 8'hC0;
      issue(RRE_OP_ROLC_ACC);
      issue_in = 0;
      chk({mem_we_out, acc_out, carry_out}, 10'h101);
      step;
      chk({mem_we_out, acc_out, carry_out}, 10'h101);
      $display("mid-run reset test done");
      give_verdict;
   end
endmodule
`default_nettype wire
